// [pcpm_pkg.sv]
/*
 Package for the multiplexed eight-pin port: register indices, reset values,
 pin positions and the struct that carries peripheral requests.
 Assumes a single clock domain and a plain register port on the processor side.
*/
package pcpm_pkg;
   localparam int unsigned PCPM_WIDTH = 8;
   localparam logic [0:0] PCPM_IDX_LATCH = 1'h0;
   localparam logic [0:0] PCPM_IDX_DIR = 1'h1;
   localparam logic [7:0] PCPM_LATCH_RST = 8'h00;
   localparam logic [7:0] PCPM_DIR_RST = 8'hff;
   localparam int unsigned PCPM_PIN_T1 = 0;
   localparam int unsigned PCPM_PIN_T1I = 1;
   localparam int unsigned PCPM_PIN_CAPTURE_COMPARE_PWM_ONE = 2;
   localparam int unsigned PCPM_PIN_SCK = 3;
   localparam int unsigned PCPM_PIN_SDI = 4;
   localparam int unsigned PCPM_PIN_SDO = 5;
   localparam int unsigned PCPM_PIN_TX = 6;
   localparam int unsigned PCPM_PIN_RX = 7;

   // One peripheral's claim on a pin
   typedef struct packed {
      logic en;
      logic force_out;
      logic force_in;
      logic data;
   } pcpm_claim_s;

   typedef enum logic [1:0] {
      PCPM_OWN_GPIO,
      PCPM_OWN_OUT,
      PCPM_OWN_IN
   } pcpm_own_e;
endpackage : pcpm_pkg

// [pcpm_pin_cell.sv]
/*
 One pin cell: resolves direction and drive from the direction bit,
 the output latch and an optional peripheral claim.
 Assumes claims are already gated by device variant.
*/
`timescale 1ns/1ns
`default_nettype none
module pcpm_pin_cell
   import pcpm_pkg::*;
(
   input  wire logic        i_dir_in,
   input  wire logic        i_latch,
   input  wire pcpm_claim_s i_claim,
   output logic             o_drive,
   output logic             o_oe_n,
   output pcpm_own_e        o_own
);
   wire claim_out = i_claim.en & i_claim.force_out;
   wire claim_in  = i_claim.en & i_claim.force_in & ~claim_out;

   // Override lasts while the claim is enabled
   assign o_own   = claim_out ? PCPM_OWN_OUT : (claim_in ? PCPM_OWN_IN : PCPM_OWN_GPIO); // RQ6
   assign o_oe_n  = claim_out ? 1'b0 : (claim_in ? 1'b1 : i_dir_in); // RQ3 RQ4 RQ5
   assign o_drive = claim_out ? i_claim.data : i_latch; // RQ17
endmodule : pcpm_pin_cell
`default_nettype wire

// [pcpm_port.sv]
/*
 Eight-pin general-purpose port with per-pin direction and peripheral takeover.
 Assumes pins are synchronous to i_core_clk; pin wire is resolved outside
 from o_pin_out and o_pin_oe_n.
*/
// Function
// RQ1: Eight pins, each usable as input or output.
// RQ2: Direction bit n controls pin n independently.
// RQ3: Direction one means input, zero means output.
// RQ4: Some enabled peripherals force their pin to output.
// RQ5: Other enabled peripherals force their pin to input.
// RQ6: Override holds exactly while the peripheral stays enabled.
// RQ7: Software avoids read-modify-write of direction while overrides active.
// RQ8: Pin 0 is GPIO, timer1 oscillator output or timer1 clock input.
// RQ9: Pin 1 is GPIO, timer1 oscillator input or second capture/compare/PWM.
// RQ10: Pin 2 is GPIO or first capture/compare/PWM.
// RQ11: Pin 3 carries serial clock in SPI and I2C modes.
// RQ12: Pin 4 is SPI data input or I2C data line.
// RQ13: Pin 5 is GPIO or serial port data output.
// RQ14: Pin 6 is GPIO, USART transmit or USART sync clock.
// RQ15: Pin 7 is GPIO, USART receive or USART sync data.
// RQ16: Reduced variant lacks second CCP on pin 1 and USART pins.
// RQ17: Data write loads latches; read returns pin levels.
`timescale 1ns/1ns
`default_nettype none
module pcpm_port
   import pcpm_pkg::*;
#(
   parameter int unsigned WIDTH   = PCPM_WIDTH,
   parameter bit          REDUCED = 1'b0
)
(
   input  wire logic              i_core_clk,
   input  wire logic              i_srst,
   input  wire logic [0:0]        i_addr,
   input  wire logic [WIDTH-1:0]  i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [WIDTH-1:0]       o_rdata,
   input  wire logic [WIDTH-1:0]  i_pin_in,
   output logic [WIDTH-1:0]       o_pin_out,
   output logic [WIDTH-1:0]       o_pin_oe_n,
   input  wire pcpm_claim_s       i_timer1_osc,
   input  wire pcpm_claim_s       i_ccp_one,
   input  wire pcpm_claim_s       i_ccp_two,
   input  wire pcpm_claim_s       i_ssp_clock,
   input  wire pcpm_claim_s       i_ssp_data_in,
   input  wire pcpm_claim_s       i_ssp_data_out,
   input  wire pcpm_claim_s       i_usart_tx_ck,
   input  wire pcpm_claim_s       i_usart_rx_dt,
   output logic [WIDTH-1:0]       o_pin_level,
   output logic [2*WIDTH-1:0]     o_pin_owner
);
   logic [WIDTH-1:0] pin_level_latch;
   logic [WIDTH-1:0] pin_direction_reg;
   logic [WIDTH-1:0] rdata_reg;
   logic [WIDTH-1:0] rdata_next;
   pcpm_claim_s      claims [WIDTH];
   pcpm_own_e        own    [WIDTH];

   function automatic pcpm_claim_s gate(input pcpm_claim_s c, input bit avail);
      pcpm_claim_s r;
      r = c;
      r.en = c.en & avail;
      return r;
   endfunction : gate

   // Peripheral claims per pin
   assign claims[PCPM_PIN_T1]   = i_timer1_osc; // RQ8
   wire ccp_two_live = i_ccp_two.en & !REDUCED;
   assign claims[PCPM_PIN_T1I]  = ccp_two_live ? i_ccp_two : i_timer1_osc; // RQ9 RQ16
   assign claims[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE] = i_ccp_one; // RQ10
   assign claims[PCPM_PIN_SCK]  = i_ssp_clock; // RQ11
   assign claims[PCPM_PIN_SDI]  = i_ssp_data_in; // RQ12
   assign claims[PCPM_PIN_SDO]  = i_ssp_data_out; // RQ13
   assign claims[PCPM_PIN_TX]   = gate(i_usart_tx_ck, !REDUCED); // RQ14 RQ16
   assign claims[PCPM_PIN_RX]   = gate(i_usart_rx_dt, !REDUCED); // RQ15 RQ16

   // One cell per pin
   for (genvar n = 0; n < WIDTH; n++)
   begin : g_pin
      pcpm_pin_cell u_cell (
         .i_dir_in (pin_direction_reg[n]), // RQ2
         .i_latch  (pin_level_latch[n]),
         .i_claim  (claims[n]),
         .o_drive  (o_pin_out[n]),
         .o_oe_n   (o_pin_oe_n[n]),
         .o_own    (own[n])
      ); // RQ1
      assign o_pin_owner[2*n +: 2] = own[n];
   end

   wire wr_latch = i_wr && (i_addr == PCPM_IDX_LATCH);
   wire wr_dir   = i_wr && (i_addr == PCPM_IDX_DIR);

   // Read path: levels for data register, stored bits for direction
   assign rdata_next = !i_rd ? '0 :
                       (i_addr == PCPM_IDX_LATCH) ? i_pin_in : pin_direction_reg; // RQ17
   assign o_rdata     = rdata_reg;
   assign o_pin_level = i_pin_in;

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         pin_level_latch   <= PCPM_LATCH_RST;
         pin_direction_reg <= PCPM_DIR_RST;
         rdata_reg         <= '0;
      end
      else
      begin
         if (wr_latch)
            pin_level_latch <= i_wdata; // RQ17
         if (wr_dir)
            pin_direction_reg <= i_wdata; // RQ2 RQ7
         rdata_reg <= rdata_next;
      end
   end

   // Checks
   a_dir_sets_oe: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (own[PCPM_PIN_SDO] == PCPM_OWN_GPIO) |-> (o_pin_oe_n[PCPM_PIN_SDO] == pin_direction_reg[PCPM_PIN_SDO]))
      else $error("direction bit not applied"); // RQ3
   a_write_dir_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
      wr_dir |=> (pin_direction_reg == $past(i_wdata)))
      else $error("direction write lost"); // RQ2
   a_write_latch_lands: assert property (@(posedge i_core_clk) disable iff (i_srst)
      wr_latch |=> (pin_level_latch == $past(i_wdata)))
      else $error("latch write lost"); // RQ17
   a_read_returns_pins: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_rd && i_addr == PCPM_IDX_LATCH) |=> (o_rdata == $past(i_pin_in)))
      else $error("data read wrong"); // RQ17
   a_force_out_drive: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_ssp_data_out.en && i_ssp_data_out.force_out) |-> !o_pin_oe_n[PCPM_PIN_SDO])
      else $error("forced output not driving"); // RQ4
   a_force_in_float: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_ssp_data_in.en && i_ssp_data_in.force_in && !i_ssp_data_in.force_out)
      |-> o_pin_oe_n[PCPM_PIN_SDI])
      else $error("forced input still driving"); // RQ5
   a_release_restores: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (!i_ccp_one.en) |-> (o_pin_oe_n[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE] == pin_direction_reg[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE]))
      else $error("override outlived enable"); // RQ6
   a_reduced_usart_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
      REDUCED |-> (own[PCPM_PIN_TX] == PCPM_OWN_GPIO && own[PCPM_PIN_RX] == PCPM_OWN_GPIO))
      else $error("usart active on reduced part"); // RQ16
   a_idle_read_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
      !i_rd |=> (o_rdata == '0))
      else $error("read data without read"); // RQ17
   a_forced_out_data: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (i_ssp_data_out.en && i_ssp_data_out.force_out)
      |-> (o_pin_out[PCPM_PIN_SDO] == i_ssp_data_out.data))
      else $error("forced output data wrong"); // RQ4
   a_gpio_drives_latch: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (own[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE] == PCPM_OWN_GPIO)
      |-> (o_pin_out[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE] == pin_level_latch[PCPM_PIN_CAPTURE_COMPARE_PWM_ONE]))
      else $error("gpio pin not driving latch"); // RQ17
   a_level_copy: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_pin_level == i_pin_in)
      else $error("pin level copy wrong"); // RQ17
   a_reduced_ccp_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
      (REDUCED && !i_timer1_osc.en) |-> (own[PCPM_PIN_T1I] == PCPM_OWN_GPIO))
      else $error("second ccp active on reduced part"); // RQ16
endmodule : pcpm_port
`default_nettype wire

// [pcpm_pin_model.sv]
/*
 Pin-side model: resolves each pin wire from the port drive and an outside source.
 Assumes the outside source drives every pin that the port leaves floating.
*/
`timescale 1ns/1ns
`default_nettype none
module pcpm_pin_model (
   input  wire logic [7:0] i_oe_n,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_ext,
   output logic      [7:0] o_level
);
   // Port drive wins where enabled
   assign o_level = (~i_oe_n & i_out) | (i_oe_n & i_ext);
endmodule : pcpm_pin_model
`default_nettype wire

// [tb_top.sv]
/*
 Self-checking bench for the port: registers, random directions, peripheral claims.
 Assumes the pin model closes the loop from pin drive to pin input.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g,e) begin n_checks++; if ((g)!==(e)) begin mismatches++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   import pcpm_pkg::*;
   logic        i_core_clk = 1'b0;
   logic        i_srst = 1'b1, i_addr = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [7:0]  i_wdata = 8'h00, ext = 8'h5a, dir, lvl, o_rdata, o_pin_out, o_pin_oe_n;
   logic [7:0]  r_oe_n, plvl;
   logic [15:0] owner;
   logic [31:0] seed = 32'h3b8e;
   pcpm_claim_s cl [8];
   int          mismatches = 0, n_checks = 0;
   always #5 i_core_clk = ~i_core_clk;
   pcpm_pin_model pcpm_pin_model_i (.i_oe_n(o_pin_oe_n), .i_out(o_pin_out), .i_ext(ext),
      .o_level(lvl));
   pcpm_port pcpm_port_i (.i_core_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_pin_in(lvl), .o_pin_out, .o_pin_oe_n, .i_timer1_osc(cl[0]), .i_ccp_two(cl[1]),
      .i_ccp_one(cl[2]), .i_ssp_clock(cl[3]), .i_ssp_data_in(cl[4]), .i_ssp_data_out(cl[5]),
      .i_usart_tx_ck(cl[6]), .i_usart_rx_dt(cl[7]), .o_pin_level(plvl), .o_pin_owner(owner));
   pcpm_port #(.REDUCED(1'b1)) pcpm_port_red_i (.i_core_clk, .i_srst, .i_addr, .i_wdata,
      .i_wr, .i_rd, .o_rdata(), .i_pin_in(lvl), .o_pin_out(), .o_pin_oe_n(r_oe_n),
      .i_timer1_osc(cl[0]), .i_ccp_two(cl[1]), .i_ccp_one(cl[2]), .i_ssp_clock(cl[3]),
      .i_ssp_data_in(cl[4]), .i_ssp_data_out(cl[5]), .i_usart_tx_ck(cl[6]),
      .i_usart_rx_dt(cl[7]), .o_pin_level(), .o_pin_owner());
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] exp_lvl(input logic [7:0] d, l, e);
      return (~d & l) | (d & e);
   endfunction : exp_lvl
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge i_core_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_core_clk) i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic a, input logic [7:0] e);
      @(posedge i_core_clk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_core_clk) i_rd <= 1'b0;
      #1 `CHK(o_rdata, e)
   endtask : rd
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   initial
   begin
      foreach (cl[i]) cl[i] = '0;
      repeat (5) @(posedge i_core_clk);
      i_srst <= 1'b0;
      #1 `CHK(o_pin_oe_n, PCPM_DIR_RST)
      rd(1'b1, PCPM_DIR_RST);
      wr(1'b1, 8'hcf);
      `CHK(o_pin_oe_n, 8'hcf)
      wr(1'b0, 8'h30);
      `CHK(o_pin_out[5:4], 2'h3)
      rd(1'b0, exp_lvl(8'hcf, 8'h30, ext));
      $display("test basic done");
      for (int n = 0; n < 40; n++)
      begin
         seed = lfsr(seed);
         ext <= seed[23:16];
         dir = seed[7:0];
         wr(1'b1, dir);
         wr(1'b0, seed[15:8]);
         `CHK(o_pin_oe_n, dir)
         `CHK(plvl, exp_lvl(dir, seed[15:8], ext))
         rd(1'b0, exp_lvl(dir, seed[15:8], ext));
         rd(1'b1, dir);
      end
      $display("test random done");
      for (int k = 0; k < 2; k++)
      begin
         dir = k ? 8'h00 : 8'hff;
         wr(1'b1, dir);
         for (int p = 0; p < 8; p++)
            for (int m = 0; m < 2; m++)
            begin
               @(posedge i_core_clk) cl[p] <= '{1'b1, ~m[0], m[0], k[0]};
               #1 `CHK(o_pin_oe_n[p], m[0])
               if (m == 0) `CHK(o_pin_out[p], k[0])
               `CHK(owner[2*p+:2], m ? PCPM_OWN_IN : PCPM_OWN_OUT)
               if (p == 1 || p > 5) `CHK(r_oe_n[p], dir[p])
               @(posedge i_core_clk) cl[p] <= '0;
               #1 `CHK(o_pin_oe_n[p], dir[p])
            end
      end
      $display("test claims done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
